// *** pkg/lq_variance_regs.vh ***
/*
 * register map, field positions and timing counts of the link quality
 * and variance readout block.
 * assumes: included by the rtl files by bare name; apb byte addressing.
 */
// Overview of operation
// - 32-bit variance sum read through one 16-bit read-only data port, two reads
// - data port content valid only while the ready flag is set
// - after hold, first data read gives low half, second the high half
// - monitor enable bit 15, rw, reset 0, effective only with 100 Mb link
// - threshold at its maximum or minimum value can never be crossed
// - threshold violation raises interrupt when the external enable is set
// - reading monitor register clears all warning flags and re-arms interrupt
// - sticky clear-on-read flags: freq control hi 9/lo 8, offset hi 7/lo 6
// - sticky flags: wander hi 5/lo 4, gain hi 3/lo 2, eq coeff hi 1/lo 0
// - monitor bits 14 to 10 reserved: writes ignored, read zero
// - monitor status can trigger an automatic 100 Mb link reset
// - thresholds and parameters go through a separate data register
// - ready flag at bit 15 clears after two consecutive data reads
// - hold bit clears after two consecutive data reads, releasing loads
// - sums load when period elapses: 2, 4, 6 or 8 ms, default 2 ms
`ifndef LQ_VARIANCE_REGS_VH
`define LQ_VARIANCE_REGS_VH

// printed offsets are register indices; byte address is four times
`define IDX_VAR_CTRL 8'h1A
`define IDX_VSUM_PORT 8'h1B
`define IDX_MON 8'h1D
`define IDX_THR 8'h1E
`define IDX_IRQ_STAT 8'h20
`define IDX_IRQ_MASK 8'h21
`define IDX_AUTO_RST 8'h22

// variance control fields
`define VC_RDY 15
`define VC_HOLD 3
`define VC_TMR_HI 2
`define VC_TMR_LO 1
`define VC_EN 0

// monitor register fields
`define MON_EN 15
`define MON_FLAGS_W 10
`define MON_RESET 16'h0000

// threshold access fields
`define THR_SAMPLE 13
`define THR_WRITE 12
`define THR_PSEL_HI 11
`define THR_PSEL_LO 9
`define THR_HISEL 8

// interrupt status bits
`define IRQ_VAR_RDY 0
`define IRQ_LQ_WARN 1
`define IRQ_W 2

// timing: one period unit is 1.048576 ms
`define UNIT_NS 1048576
`define CLK_NS 40
`define UNIT_CYC (`UNIT_NS / `CLK_NS)

`endif

// *** rtl/link_quality_variance_regs.v ***
/*
 * apb register bank for the variance readout and the link quality monitor:
 * variance control/data, monitor status, threshold access, irq status/mask
 * and auto link reset control.
 * assumes: apb master per amba apb; dsp parameters and variance sum are
 * synchronous to clock_i; link_up_i is an asynchronous status pin.
 */
`timescale 1ns/1ps
`include "lq_variance_regs.vh"
module link_quality_variance_regs #(
  parameter PW = 8,
  parameter UNIT_CYC = `UNIT_CYC
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output reg [31:0] prdata_o,
  output wire pslverr_o,
  input wire link_up_i,
  input wire lq_irq_en_i,
  input wire [31:0] variance_sum_i,
  input wire [5*PW-1:0] params_i,
  output wire variance_run_o,
  output wire lq_irq_o,
  output reg link_reset_o,
  output wire irq_o
);
  localparam NP = 5;

  // apb decode
  wire [9:0] idx = paddr_i[11:2];
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i;
  wire rd = acc && !pwrite_i;
  wire hit_vc = idx == {2'b00, `IDX_VAR_CTRL};
  wire hit_vd = idx == {2'b00, `IDX_VSUM_PORT};
  wire hit_mon = idx == {2'b00, `IDX_MON};
  wire hit_thr = idx == {2'b00, `IDX_THR};
  wire hit_ist = idx == {2'b00, `IDX_IRQ_STAT};
  wire hit_imk = idx == {2'b00, `IDX_IRQ_MASK};
  wire hit_ar = idx == {2'b00, `IDX_AUTO_RST};
  wire hit_any = hit_vc || hit_vd || hit_mon || hit_thr || hit_ist || hit_imk || hit_ar;
  // zero-wait slave; unmapped addresses answer with an error
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !hit_any;

  // link-up pin: three flops, change accepted when second and third agree
  reg [2:0] link_sync;
  reg link_ok;
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_sync <= 3'b000;
      link_ok <= 1'b0;
    end else begin
      link_sync <= {link_sync[1:0], link_up_i};
      if (link_sync[1] == link_sync[2])
        link_ok <= link_sync[2];
    end
  end

  // variance control and data port
  reg var_en;
  reg var_hold;
  reg var_rdy;
  reg [1:0] var_sel;
  reg [31:0] var_sum;
  reg second_read; // next data read returns the high half
  wire tmr_done;
  wire vc_write = wr && hit_vc;
  wire vd_read = rd && hit_vd;
  assign variance_run_o = var_en;

  variance_period_timer #(
    .UNIT_CYC(UNIT_CYC)
  ) u_timer (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .run_i(var_en),
    .restart_i(vc_write),
    .sel_i(var_sel),
    .done_o(tmr_done)
  );

  // new sums load only at period end and never while held
  wire var_load = tmr_done && !var_hold;
  wire pair_done = vd_read && second_read;

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      var_en <= 1'b0;
      var_hold <= 1'b0;
      var_rdy <= 1'b0;
      var_sel <= 2'b00; // default 2 ms
      var_sum <= 32'h0;
      second_read <= 1'b0;
    end else begin
      if (var_load)
        var_sum <= variance_sum_i;
      // low half first, high half next; a pair ends both flags
      if (vd_read)
        second_read <= !second_read;
      else if (vc_write && pwdata_i[`VC_HOLD])
        second_read <= 1'b0; // setting hold restarts the pair
      if (vc_write) begin
        var_en <= pwdata_i[`VC_EN];
        var_sel <= pwdata_i[`VC_TMR_HI:`VC_TMR_LO];
      end
      // a load is a set event and beats the pair-read clear
      if (var_load)
        var_rdy <= 1'b1;
      else if (pair_done)
        var_rdy <= 1'b0;
      if (pair_done)
        var_hold <= 1'b0;
      else if (vc_write)
        var_hold <= pwdata_i[`VC_HOLD];
    end
  end

  // threshold storage via threshold access register
  reg [PW-1:0] thr_hi [0:NP-1];
  reg [PW-1:0] thr_lo [0:NP-1];
  reg [2:0] thr_psel;
  reg thr_hisel;
  reg thr_sample;
  reg [PW-1:0] thr_data;
  wire thr_write = wr && hit_thr && pwdata_i[`THR_WRITE];
  wire [2:0] wsel = pwdata_i[`THR_PSEL_HI:`THR_PSEL_LO];
  wire [NP-1:0] trip_hi;
  wire [NP-1:0] trip_lo;

  // per-parameter compare; reset thresholds are the disabling extremes
  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : g_par
      threshold_check #(
        .W(PW)
      ) u_chk (
        .value_i(params_i[g*PW +: PW]),
        .high_i(thr_hi[g]),
        .low_i(thr_lo[g]),
        .high_o(trip_hi[g]),
        .low_o(trip_lo[g])
      );
      always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          thr_hi[g] <= {PW{1'b1}};
          thr_lo[g] <= {PW{1'b0}};
        end else if (thr_write && wsel == g) begin
          if (pwdata_i[`THR_HISEL])
            thr_hi[g] <= pwdata_i[PW-1:0];
          else
            thr_lo[g] <= pwdata_i[PW-1:0];
        end
      end
    end
  endgenerate

  // selected parameter or threshold captured for readback
  wire [PW-1:0] sel_param = params_i[thr_psel*PW +: PW];
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      thr_psel <= 3'b000;
      thr_hisel <= 1'b0;
      thr_sample <= 1'b0;
      thr_data <= {PW{1'b0}};
    end else begin
      if (wr && hit_thr) begin
        thr_psel <= wsel;
        thr_hisel <= pwdata_i[`THR_HISEL];
        thr_sample <= pwdata_i[`THR_SAMPLE];
      end
      if (thr_psel < 3'h5)
        thr_data <= thr_sample ? sel_param
                   : (thr_hisel ? thr_hi[thr_psel] : thr_lo[thr_psel]);
      else
        thr_data <= {PW{1'b0}};
    end
  end

  // monitor: enable and sticky warning flags
  reg mon_en;
  reg [`MON_FLAGS_W-1:0] warn;
  reg lq_irq;
  wire mon_active = mon_en && link_ok;
  wire mon_read = rd && hit_mon;
  // flag order: eq coeff lo/hi, gain, wander, freq offset, freq control
  wire [`MON_FLAGS_W-1:0] trips = {trip_hi[4], trip_lo[4], trip_hi[3], trip_lo[3],
                                   trip_hi[2], trip_lo[2], trip_hi[1], trip_lo[1],
                                   trip_hi[0], trip_lo[0]};
  wire [`MON_FLAGS_W-1:0] new_warn = mon_active ? trips : {`MON_FLAGS_W{1'b0}};

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mon_en <= 1'b0;
      warn <= {`MON_FLAGS_W{1'b0}};
      lq_irq <= 1'b0;
    end else begin
      if (wr && hit_mon)
        mon_en <= pwdata_i[`MON_EN]; // reserved bits ignored
      // read clears, a same-cycle crossing still sets
      if (mon_read)
        warn <= new_warn;
      else
        warn <= warn | new_warn;
      // request held until monitor read re-arms it
      if ((|new_warn) && lq_irq_en_i)
        lq_irq <= 1'b1;
      else if (mon_read)
        lq_irq <= 1'b0;
    end
  end
  assign lq_irq_o = lq_irq;

  // automatic link reset on any warning when enabled
  reg auto_rst_en;
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      auto_rst_en <= 1'b0;
      link_reset_o <= 1'b0;
    end else begin
      if (wr && hit_ar)
        auto_rst_en <= pwdata_i[0];
      link_reset_o <= auto_rst_en && (|new_warn);
    end
  end

  // block interrupt: sticky status, write one to clear, set wins
  reg [`IRQ_W-1:0] irq_stat;
  reg [`IRQ_W-1:0] irq_mask;
  wire [`IRQ_W-1:0] irq_ev;
  assign irq_ev[`IRQ_VAR_RDY] = var_load;
  assign irq_ev[`IRQ_LQ_WARN] = (|new_warn) && lq_irq_en_i;
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat <= {`IRQ_W{1'b0}};
      irq_mask <= {`IRQ_W{1'b0}};
    end else begin
      if (wr && hit_imk)
        irq_mask <= pwdata_i[`IRQ_W-1:0];
      if (wr && hit_ist)
        irq_stat <= (irq_stat & ~pwdata_i[`IRQ_W-1:0]) | irq_ev;
      else
        irq_stat <= irq_stat | irq_ev;
    end
  end
  assign irq_o = |(irq_stat & irq_mask);

  // read mux, combinational so read data is valid in the access cycle
  always @* begin
    prdata_o = 32'h0;
    if (hit_vc)
      prdata_o = {16'h0, var_rdy, 11'h0, var_hold, var_sel, var_en};
    else if (hit_vd)
      prdata_o = {16'h0, second_read ? var_sum[31:16] : var_sum[15:0]};
    else if (hit_mon)
      prdata_o = {16'h0, mon_en, 5'h00, warn};
    else if (hit_thr)
      prdata_o = {16'h0, 2'b00, thr_sample, 1'b0, thr_psel, thr_hisel, thr_data};
    else if (hit_ist)
      prdata_o = {30'h0, irq_stat};
    else if (hit_imk)
      prdata_o = {30'h0, irq_mask};
    else if (hit_ar)
      prdata_o = {31'h0, auto_rst_en};
  end
endmodule // link_quality_variance_regs

// *** rtl/threshold_check.v ***
/*
 * one parameter's high/low threshold compare; extreme thresholds never trip.
 * assumes: parameters and thresholds are unsigned, same width.
 */
`timescale 1ns/1ps
module threshold_check #(
  parameter W = 8
) (
  input wire [W-1:0] value_i,
  input wire [W-1:0] high_i,
  input wire [W-1:0] low_i,
  output wire high_o,
  output wire low_o
);
  // a high limit at max or low limit at min disables that side
  assign high_o = (high_i != {W{1'b1}}) && (value_i > high_i);
  assign low_o = (low_i != {W{1'b0}}) && (value_i < low_i);
endmodule // threshold_check

// *** rtl/variance_period_timer.v ***
/*
 * variance computation period timer: pulses when the selected
 * 2/4/6/8 unit period elapses.
 * assumes: restart pulses for one cycle whenever the period field is written.
 */
`timescale 1ns/1ps
module variance_period_timer #(
  parameter UNIT_CYC = 26214
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire run_i,
  input wire restart_i,
  input wire [1:0] sel_i,
  output reg done_o
);
  reg [31:0] unit_cnt;
  reg [3:0] units;
  wire [3:0] target = {1'b0, sel_i, 1'b0} + 4'h2; // 2,4,6,8 units

  // count whole units, then units up to the target; restart on write
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      unit_cnt <= 32'h0;
      units <= 4'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!run_i || restart_i) begin
        unit_cnt <= 32'h0;
        units <= 4'h0;
      end else if (unit_cnt == UNIT_CYC - 1) begin
        unit_cnt <= 32'h0;
        if (units + 4'h1 >= target) begin
          units <= 4'h0;
          done_o <= 1'b1;
        end else begin
          units <= units + 4'h1;
        end
      end else begin
        unit_cnt <= unit_cnt + 32'h1;
      end
    end
  end
endmodule // variance_period_timer

// *** verif/link_quality_variance_regs_sva.sv ***
/*
 * checker for the link quality and variance register bank.
 * assumes: bound to the top module; apb has zero wait states.
 */
`timescale 1ns/1ps
module link_quality_variance_regs_sva (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic link_up_i,
  input wire logic lq_irq_en_i,
  input wire logic lq_irq_o,
  input wire logic variance_run_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // access-phase decodes
  wire acc = psel_i && penable_i;
  wire rd = acc && !pwrite_i;
  wire rd_mon = rd && paddr_i == 12'h074;
  a_ready_always: assert property (pready_o) else $error("pready low");
  a_unmapped_err: assert property (rd && paddr_i == 12'h070 |-> pslverr_o && prdata_o == 0)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (acc && paddr_i == 12'h074 |-> !pslverr_o) else $error("bad err");
  a_mon_reserved: assert property (rd_mon |-> prdata_o[31:16] == 0 && prdata_o[14:10] == 0)
    else $error("monitor reserved bits set");
  // bit 13 reads back the sample control; only the write strobe and 15:14 read zero
  a_thr_strobe: assert property (rd && paddr_i == 12'h078 |-> prdata_o[15:14] == 0 && !prdata_o[12])
    else $error("threshold strobe reads one");
  a_ctrl_reserved: assert property (rd && paddr_i == 12'h068 |-> prdata_o[14:4] == 0)
    else $error("ctrl reserved bits set");
  a_data_half: assert property (rd && paddr_i == 12'h06C |-> prdata_o[31:16] == 0)
    else $error("data wider than 16 bits");
  a_irq_needs_en: assert property ($rose(lq_irq_o) |-> $past(lq_irq_en_i))
    else $error("irq without enable");
  a_irq_holds: assert property (lq_irq_o && !rd_mon |=> lq_irq_o)
    else $error("irq dropped before read");
  a_irq_clears: assert property (rd_mon && !lq_irq_en_i |=> !lq_irq_o)
    else $error("irq not cleared by read");
  a_no_link_irq: assert property (!link_up_i [*8] |-> !$rose(lq_irq_o))
    else $error("irq without link");
  a_run_by_write: assert property ($changed(variance_run_o) |->
    $past(acc && pwrite_i && paddr_i == 12'h068)) else $error("run changed alone");
  c_irq_read: cover property (rd_mon && lq_irq_o);
  c_irq_rise: cover property ($rose(lq_irq_o));
  c_unmapped: cover property (rd && paddr_i == 12'h070);
endmodule // link_quality_variance_regs_sva

bind link_quality_variance_regs link_quality_variance_regs_sva u_sva (.clock_i(clock_i),
  .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .link_up_i(link_up_i), .lq_irq_en_i(lq_irq_en_i), .lq_irq_o(lq_irq_o),
  .variance_run_o(variance_run_o));

// *** verif/test_link_quality_variance_regs.sv ***
/*
 * self-checking bench for the link quality and variance register bank.
 * assumes: unit period shortened to 4 cycles; apb answers at once.
 */
`timescale 1ns/1ps
module test_link_quality_variance_regs;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic link_up = 1'b1;
  logic irq_en = 1'b0;
  logic [31:0] vsum = 32'h0;
  logic [39:0] params = 40'h0;
  wire pready, pslverr, run, lq_irq, link_rst, irq;
  wire [31:0] prdata;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int per;
  logic [31:0] rd, old;
  logic [7:0] p, t;
  always #20 clock_i = ~clock_i;
  link_quality_variance_regs #(.PW(8), .UNIT_CYC(4)) u_dut (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .link_up_i(link_up), .lq_irq_en_i(irq_en), .variance_sum_i(vsum),
    .params_i(params), .variance_run_o(run), .lq_irq_o(lq_irq), .link_reset_o(link_rst),
    .irq_o(irq));
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    // wait for the answer however long it takes; only the hang guard ends it
    while (pready !== 1'b1) begin
      n++;
      @(posedge clock_i);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // hang guard: far above the roughly 630 cycles the run needs
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h9D24));
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rdc(12'h074, 32'h0);
    rdc(12'h06C, 32'h0);
    rdc(12'h070, 32'h0);
    apb(1'b1, 12'h074, 32'hFFFF);
    rdc(12'h074, 32'h8000);
    apb(1'b1, 12'h084, 32'h2);
    apb(1'b1, 12'h088, 32'h1);
    // trip each threshold in turn, high and low
    for (int s = 0; s < 5; s++) begin
      for (int h = 0; h < 2; h++) begin
        p = 8'h10 + 8'($urandom % 224);
        params[s*8 +: 8] <= p;
        // high side always enabled so the status bit is surely raised
        irq_en <= h ? 1'b1 : 1'($urandom);
        t = h ? p - 8'h01 : p + 8'h01;
        apb(1'b1, 12'h078, 32'h1000 | (s << 9) | (h << 8) | t);
        rdc(12'h074, 32'h8000 | (32'h1 << (2 * s + h)));
        chk(lq_irq, irq_en);
        chk(link_rst, 1'b1);
        // sample the live parameter and read it back
        apb(1'b1, 12'h078, 32'h2000 | (s << 9));
        rdc(12'h078, 32'h2000 | (s << 9) | p);
        apb(1'b1, 12'h078, 32'h1000 | (s << 9) | (h << 8) | (h ? 32'hFF : 32'h0));
        apb(1'b0, 12'h074, 32'h0);
        rdc(12'h074, 32'h8000);
        @(negedge clock_i);
        chk(lq_irq, 1'b0);
      end
    end
    rdc(12'h080, 32'h2);
    chk(irq, 1'b1);
    apb(1'b1, 12'h084, 32'h0);
    @(negedge clock_i);
    chk(irq, 1'b0);
    apb(1'b1, 12'h080, 32'h2);
    rdc(12'h080, 32'h0);
    // extreme values against disabled thresholds never trip
    params <= 40'hFFFFFFFFFF;
    repeat (3) @(posedge clock_i);
    rdc(12'h074, 32'h8000);
    params <= 40'h0;
    link_up <= 1'b0;
    repeat (10) @(posedge clock_i);
    rdc(12'h074, 32'h8000);
    // a real crossing with the link down must not flag
    params <= 40'h05;
    apb(1'b1, 12'h078, 32'h1101);
    repeat (3) @(posedge clock_i);
    rdc(12'h074, 32'h8000);
    // variance readout for every period setting
    for (int sel = 0; sel < 4; sel++) begin
      per = (2 * sel + 2) * 4;
      vsum <= $urandom;
      apb(1'b1, 12'h068, (sel << 1) | 1);
      // enable lands at the access edge; look once it has settled
      @(negedge clock_i);
      chk(run, 1'b1);
      repeat (per / 2) @(posedge clock_i);
      apb(1'b0, 12'h068, 32'h0);
      chk(rd[15], 1'b0);
      repeat (per) @(posedge clock_i);
      apb(1'b0, 12'h068, 32'h0);
      chk(rd[15], 1'b1);
      old = vsum;
      apb(1'b1, 12'h068, 32'h8 | (sel << 1) | 1);
      vsum <= $urandom;
      repeat (per + 4) @(posedge clock_i);
      rdc(12'h06C, old[15:0]);
      rdc(12'h06C, old[31:16]);
      apb(1'b0, 12'h068, 32'h0);
      chk(rd[3], 1'b0);
      apb(1'b1, 12'h068, sel << 1);
      apb(1'b0, 12'h06C, 32'h0);
      apb(1'b0, 12'h06C, 32'h0);
      rdc(12'h068, sel << 1);
    end
    test_done();
  end
endmodule // test_link_quality_variance_regs
